// ### pkg/pmx_params.svh
// constants for the port pin function multiplexer
`ifndef PMX_PARAMS_SVH
`define PMX_PARAMS_SVH
// bank geometry
`define PMX_NPORT       7
`define PMX_NIRQ        6
// bank index of each port
`define PMX_IDX_A       0
`define PMX_IDX_B       1
`define PMX_IDX_C       2
`define PMX_IDX_D       3
`define PMX_IDX_F       4
`define PMX_IDX_G       5
`define PMX_IDX_L       6
// configuration field codes
`define PMX_FLD_LATCH   3'h0
`define PMX_FLD_DIR     3'h1
`define PMX_FLD_PULLUP  3'h2
`define PMX_FLD_MODE    3'h3
`define PMX_FLD_EDGE    3'h4
// implemented bits and pull-up capable bits, a b c d f g l
`define PMX_IMPL_MASKS  '{8'h7F, 8'hFF, 8'hFF, 8'h0F, 8'h03, 8'hFF, 8'h1F}
`define PMX_PU_MASKS    '{8'h7F, 8'hFF, 8'h00, 8'h0F, 8'h00, 8'hFF, 8'h01}
// reset values
`define PMX_LATCH_RST   8'h00
`define PMX_DIR_RST     8'hFF
`define PMX_PU_RST      8'h00
`define PMX_MODE_RST    8'h00
`define PMX_MODE_RST_C  8'hFF
`define PMX_EDGE_RST    2'h1
`endif

// ### pkg/pmx_pkg.sv
// types shared by the port pin function multiplexer
package pmx_pkg;
  typedef enum logic [2:0] {
    FLD_LATCH  = 3'h0,
    FLD_DIR    = 3'h1,
    FLD_PULLUP = 3'h2,
    FLD_MODE   = 3'h3,
    FLD_EDGE   = 3'h4
  } pmx_field_t;
  typedef enum logic [1:0] {
    EDGE_NONE = 2'h0,
    EDGE_RISE = 2'h1,
    EDGE_FALL = 2'h2,
    EDGE_BOTH = 2'h3
  } pmx_edge_t;
  // one port worth of pad drive
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pu;
  } pmx_pad_t;
  // peripheral outputs toward the pins, each with its enable except the i2c clock and data low drives
  typedef struct packed {
    logic timer_a_output;      logic timer_a_out_en;
    logic timer_b_output;      logic timer_b_out_en;
    logic csi_b_data_out;      logic csi_b_data_en;
    logic csi_b_clock_out;     logic csi_b_clock_en;
    logic csi_a_clock_out;     logic csi_a_clock_en;
    logic uart_a_tx;           logic uart_a_tx_en;
    logic csi_a_data_out;      logic csi_a_data_en;
    logic uart_b_tx;           logic uart_b_tx_en;
    logic hs_timer_a_output;   logic hs_timer_a_en;
    logic hs_timer_b_output;   logic hs_timer_b_en;
    logic byte_timer_a_output; logic byte_timer_a_en;
    logic byte_timer_b_output; logic byte_timer_b_en;
    logic i2c_clock_low;       logic i2c_data_low;
  } pmx_alt_out_t;
  // pin values handed to the peripherals
  typedef struct packed {
    logic timer_a_count_input;  logic timer_a_capture_input;
    logic timer_b_count_input;  logic timer_b_capture_input;
    logic csi_b_data_in;        logic csi_b_clock_in;
    logic serial_chip_select_in;
    logic csi_a_clock_in;       logic csi_a_data_in;
    logic uart_a_rx;            logic uart_b_rx;
    logic byte_timer_count_input; logic byte_timer_b_count_input;
    logic [7:0] analog_channel_inputs;
    logic [5:0] external_irq_inputs;
    logic [5:0] external_irq_edges;
    logic [7:0] key_irq_inputs;
    logic i2c_clock_in;         logic i2c_data_in;
    logic ext_lowvolt_detect_input;
    logic main_osc_connect;     logic sub_osc_connect;
    logic main_ext_clock_input; logic sub_ext_clock_input;
  } pmx_alt_in_t;
endpackage

// ### rtl/pmx_edge_detect.sv
// valid edge detector for one external interrupt input
`timescale 1ns/1ps
module pmx_edge_detect
  import pmx_pkg::*;
(
  input  wire logic       clk,   // system clock
  input  wire logic       rst,   // async reset, high
  input  wire logic       ce,    // clock enable
  input  wire logic       lvl,   // filtered pin level
  input  wire logic       en,    // pin in control mode
  input  pmx_pkg::pmx_edge_t sel, // valid edge choice
  output logic            pulse  // edge seen, one cycle
);
  logic prev_reg, prev_next;
  logic rise, fall;
  // =====================================================
  // previous level tracked always, so mode entry makes no edge
  always_comb
  begin
    prev_next = lvl;
  end
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      prev_reg <= 1'b0;
    else if (ce)
      prev_reg <= prev_next;
  end
  assign rise  = lvl & ~prev_reg;
  assign fall  = ~lvl & prev_reg;
  assign pulse = ce & en & ((rise & sel[0]) | (fall & sel[1]));
  // =====================================================
  a_edge_rise: assert property (@(posedge clk) disable iff (rst)
    ce && en && sel == EDGE_RISE && $rose(lvl) |-> pulse)
    else $error("rising edge missed");
  a_edge_fall: assert property (@(posedge clk) disable iff (rst)
    sel == EDGE_FALL && pulse |-> $fell(lvl))
    else $error("falling select fired on non falling edge");
endmodule // pmx_edge_detect

// ### rtl/pmx_pin_cell.sv
// one pad: input synchroniser, output select and pull-up gate
`timescale 1ns/1ps
module pmx_pin_cell #(
  parameter bit OPEN_DRAIN = 1'b0,
  parameter bit PU_OK      = 1'b0
) (
  input  wire logic clk,     // system clock
  input  wire logic rst,     // async reset, high
  input  wire logic ce,      // clock enable
  input  wire logic pad_in,  // raw pad level
  input  wire logic latch,   // port output latch
  input  wire logic dir_in,  // 1 = input
  input  wire logic ctrl,    // 1 = control mode
  input  wire logic alt_out, // peripheral output value
  input  wire logic alt_oe,  // peripheral output active
  input  wire logic pu_sel,  // pull-up selected
  output logic      pad_out, // pad output value
  output logic      pad_oe,  // pad driven
  output logic      pad_pu,  // pull-up connected
  output logic      level    // filtered pad level
);
  logic s1_reg, s2_reg, s3_reg, level_reg;
  logic s1_next, s2_next, s3_next, level_next;
  logic drive, val;
  // =====================================================
  // three stage synchroniser, level moves once 2 and 3 agree
  always_comb
  begin
    s1_next    = pad_in;
    s2_next    = s1_reg;
    s3_next    = s2_reg;
    level_next = (s2_reg == s3_reg) ? s3_reg : level_reg;
  end
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      {s1_reg, s2_reg, s3_reg, level_reg} <= 4'h0;
    end
    else if (ce)
    begin
      {s1_reg, s2_reg, s3_reg, level_reg} <=
        {s1_next, s2_next, s3_next, level_next};
    end
  end
  assign level = level_reg;
  // =====================================================
  // driver: peripheral in control mode, latch in port mode
  assign drive   = ctrl ? alt_oe : ~dir_in;
  assign val     = ctrl ? alt_out : latch;
  assign pad_out = OPEN_DRAIN ? 1'b0 : val;
  assign pad_oe  = OPEN_DRAIN ? (drive & ~val) : drive;
  assign pad_pu  = PU_OK & pu_sel & ~drive;
  // =====================================================
  sequence s_split;
    ce && (s2_reg != s3_reg);
  endsequence
  a_sync_hold: assert property (@(posedge clk) disable iff (rst)
    s_split |=> $stable(level_reg))
    else $error("level moved while sync stages disagree");
  a_sync_take: assert property (@(posedge clk) disable iff (rst)
    ce && (s2_reg == s3_reg) |=> level_reg == $past(s3_reg))
    else $error("level did not follow agreed sync stages");
endmodule // pmx_pin_cell

// ### rtl/pmx_top.sv
// port pin function multiplexer: modes, directions, pull-ups, routing
`timescale 1ns/1ps
`include "pmx_params.svh"
module pmx_top #(
  parameter int NIRQ = `PMX_NIRQ
) (
  input  wire logic          clk,                 // system clock
  input  wire logic          rst,                 // async reset, high
  input  wire logic          ce,                  // clock enable
  input  wire logic          cfg_wr,              // config write strobe
  input  wire logic [2:0]    cfg_port,            // port or irq index
  input  pmx_pkg::pmx_field_t cfg_field,          // field written
  input  wire logic [7:0]    cfg_wdata,           // write data
  input  wire logic [7:0]    pad_in [`PMX_NPORT], // raw pad levels
  output pmx_pkg::pmx_pad_t  pad [`PMX_NPORT],    // pad drive per port
  input  pmx_pkg::pmx_alt_out_t alt_out,          // peripheral outputs
  output pmx_pkg::pmx_alt_in_t  alt_in,           // peripheral inputs
  output logic [6:0]         port_a_direction,    // 1 = input
  output logic [7:0]         port_b_direction,    // 1 = input
  output logic [7:0]         port_c_direction,    // 1 = input
  output logic [3:0]         port_d_direction,    // 1 = input
  output logic [1:0]         port_f_direction,    // 1 = input
  output logic [7:0]         port_g_direction,    // 1 = input
  output logic [4:0]         port_l_direction,    // 1 = input
  output logic [6:0]         port_a_pullup_select, // pull-up choice
  output logic [7:0]         port_b_pullup_select, // pull-up choice
  output logic [3:0]         port_d_pullup_select, // pull-up choice
  output logic [7:0]         port_g_pullup_select, // pull-up choice
  output logic [0:0]         port_l_pullup_select, // pull-up choice
  output logic [7:0]         port_mode [`PMX_NPORT], // 1 = control
  output logic [7:0]         port_level [`PMX_NPORT] // filtered pins
);
  import pmx_pkg::*;
  localparam int PA = `PMX_IDX_A;
  localparam int PB = `PMX_IDX_B;
  localparam int PC = `PMX_IDX_C;
  localparam int PD = `PMX_IDX_D;
  localparam int PF = `PMX_IDX_F;
  localparam int PG = `PMX_IDX_G;
  localparam int PL = `PMX_IDX_L;
  localparam int NP = `PMX_NPORT;
  localparam logic [7:0] IMPL [NP] = `PMX_IMPL_MASKS;
  localparam logic [7:0] PUOK [NP] = `PMX_PU_MASKS;

  // =====================================================
  // parameter check
  if (NIRQ < 1 || NIRQ > `PMX_NIRQ)
  begin : g_bad_nirq
    $error("NIRQ must lie between 1 and 6");
  end

  // =====================================================
  // configuration state
  logic [7:0] latch_reg [NP], latch_next [NP];
  logic [7:0] dir_reg   [NP], dir_next   [NP];
  logic [7:0] pu_reg    [NP], pu_next    [NP];
  logic [7:0] mode_reg  [NP], mode_next  [NP];
  pmx_edge_t  edge_reg  [NIRQ], edge_next [NIRQ];
  logic [7:0] lvl [NP];
  logic [7:0] alt_o [NP], alt_e [NP];
  pmx_alt_in_t alt_in_reg, alt_in_next;
  logic [NIRQ-1:0] irq_lvl, irq_en, irq_pulse;

  // writes land in the field chosen; latch and mode masked to implemented bits, pull-up to capable bits, unimplemented direction bits set to 1
  always_comb
  begin
    latch_next = latch_reg;
    dir_next   = dir_reg;
    pu_next    = pu_reg;
    mode_next  = mode_reg;
    edge_next  = edge_reg;
    if (cfg_wr && int'(cfg_port) < NP)
    begin
      case (cfg_field)
        FLD_LATCH:  latch_next[cfg_port] = cfg_wdata & IMPL[cfg_port];
        FLD_DIR:    dir_next[cfg_port]   = cfg_wdata | ~IMPL[cfg_port];
        FLD_PULLUP: pu_next[cfg_port]    = cfg_wdata & PUOK[cfg_port];
        FLD_MODE:   mode_next[cfg_port]  = cfg_wdata & IMPL[cfg_port];
        FLD_EDGE:
        begin
          if (int'(cfg_port) < NIRQ)
            edge_next[cfg_port] = pmx_edge_t'(cfg_wdata[1:0]);
        end
        default: ;
      endcase
    end
  end

  // chip reset restores inputs everywhere, port c analog
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      latch_reg <= '{default: `PMX_LATCH_RST};
      dir_reg   <= '{default: `PMX_DIR_RST};
      pu_reg    <= '{default: `PMX_PU_RST};
      mode_reg  <= '{PC: `PMX_MODE_RST_C, default: `PMX_MODE_RST};
      edge_reg  <= '{default: pmx_edge_t'(`PMX_EDGE_RST)};
    end
    else if (ce)
    begin
      latch_reg <= latch_next;
      dir_reg   <= dir_next;
      pu_reg    <= pu_next;
      mode_reg  <= mode_next;
      edge_reg  <= edge_next;
    end
  end

  // =====================================================
  // peripheral outputs placed on their pins
  always_comb
  begin
    alt_o = '{default: 8'h00};
    alt_e = '{default: 8'h00};
    // port a: two timer outputs, clocked serial data and clock
    alt_o[PA][1] = alt_out.timer_a_output;
    alt_e[PA][1] = alt_out.timer_a_out_en;
    alt_o[PA][6] = alt_out.timer_b_output;
    alt_e[PA][6] = alt_out.timer_b_out_en;
    alt_o[PA][2] = alt_out.csi_b_data_out;
    alt_e[PA][2] = alt_out.csi_b_data_en;
    alt_o[PA][4] = alt_out.csi_b_clock_out;
    alt_e[PA][4] = alt_out.csi_b_clock_en;
    // port b: serial clock has priority over uart transmit on bit 0
    alt_o[PB][0] = alt_out.csi_a_clock_en ? alt_out.csi_a_clock_out
                                          : alt_out.uart_a_tx;
    alt_e[PB][0] = alt_out.csi_a_clock_en | alt_out.uart_a_tx_en;
    alt_o[PB][2] = alt_out.csi_a_data_out;
    alt_e[PB][2] = alt_out.csi_a_data_en;
    alt_o[PB][3] = alt_out.uart_b_tx;
    alt_e[PB][3] = alt_out.uart_b_tx_en;
    alt_o[PB][5] = alt_out.hs_timer_a_output;
    alt_e[PB][5] = alt_out.hs_timer_a_en;
    alt_o[PB][6] = alt_out.hs_timer_b_output;
    alt_e[PB][6] = alt_out.hs_timer_b_en;
    alt_o[PB][7] = alt_out.byte_timer_a_output;
    alt_e[PB][7] = alt_out.byte_timer_a_en;
    // port d: one timer output on bit 3
    alt_o[PD][3] = alt_out.byte_timer_b_output;
    alt_e[PD][3] = alt_out.byte_timer_b_en;
    // port f: open-drain i2c, clock on bit 0, data on bit 1
    alt_o[PF][0] = ~alt_out.i2c_clock_low;
    alt_e[PF][0] = 1'b1;
    alt_o[PF][1] = ~alt_out.i2c_data_low;
    alt_e[PF][1] = 1'b1;
  end

  // =====================================================
  // pad cells for every implemented bit
  for (genvar p = 0; p < NP; p++)
  begin : g_port
    for (genvar b = 0; b < 8; b++)
    begin : g_bit
      if (IMPL[p][b])
      begin : g_cell
        pmx_pin_cell #(
          .OPEN_DRAIN (p == PF),
          .PU_OK      (PUOK[p][b])
        ) u_cell (
          .clk     (clk),
          .rst     (rst),
          .ce      (ce),
          .pad_in  (pad_in[p][b]),
          .latch   (latch_reg[p][b]),
          .dir_in  (dir_reg[p][b]),
          .ctrl    (mode_reg[p][b]),
          .alt_out (alt_o[p][b]),
          .alt_oe  (alt_e[p][b]),
          .pu_sel  (pu_reg[p][b]),
          .pad_out (pad[p].out[b]),
          .pad_oe  (pad[p].oe[b]),
          .pad_pu  (pad[p].pu[b]),
          .level   (lvl[p][b])
        );
      end
      else
      begin : g_none
        assign pad[p].out[b] = 1'b0;
        assign pad[p].oe[b]  = 1'b0;
        assign pad[p].pu[b]  = 1'b0;
        assign lvl[p][b]     = 1'b0;
      end
    end
    assign port_mode[p]  = mode_reg[p];
    assign port_level[p] = lvl[p];
  end

  // =====================================================
  // external irq sources: l0, d0..d3, b6
  always_comb
  begin
    irq_lvl = '0;
    irq_en  = '0;
    for (int i = 0; i < NIRQ; i++)
    begin
      case (i)
        0:       begin irq_lvl[i] = lvl[PL][0]; irq_en[i] = mode_reg[PL][0]; end
        5:       begin irq_lvl[i] = lvl[PB][6]; irq_en[i] = mode_reg[PB][6]; end
        default: begin irq_lvl[i] = lvl[PD][i-1]; irq_en[i] = mode_reg[PD][i-1]; end
      endcase
    end
  end

  for (genvar i = 0; i < NIRQ; i++)
  begin : g_irq
    pmx_edge_detect u_edge (
      .clk   (clk),
      .rst   (rst),
      .ce    (ce),
      .lvl   (irq_lvl[i]),
      .en    (irq_en[i]),
      .sel   (edge_reg[i]),
      .pulse (irq_pulse[i])
    );
  end

  // =====================================================
  // pin values handed to peripherals, only in control mode
  always_comb
  begin
    alt_in_next = '0;
    alt_in_next.timer_a_count_input   = mode_reg[PA][0] & lvl[PA][0];
    alt_in_next.timer_a_capture_input = mode_reg[PA][1] & lvl[PA][1];
    alt_in_next.csi_b_data_in         = mode_reg[PA][3] & lvl[PA][3];
    alt_in_next.csi_b_clock_in        = mode_reg[PA][4] & lvl[PA][4];
    alt_in_next.serial_chip_select_in = mode_reg[PA][5] & lvl[PA][5];
    alt_in_next.timer_b_count_input   = mode_reg[PA][5] & lvl[PA][5];
    alt_in_next.timer_b_capture_input = mode_reg[PA][6] & lvl[PA][6];
    alt_in_next.csi_a_clock_in        = mode_reg[PB][0] & lvl[PB][0];
    alt_in_next.csi_a_data_in         = mode_reg[PB][1] & lvl[PB][1];
    alt_in_next.uart_a_rx             = mode_reg[PB][1] & lvl[PB][1];
    alt_in_next.uart_b_rx             = mode_reg[PB][4] & lvl[PB][4];
    alt_in_next.byte_timer_count_input = mode_reg[PB][7] & lvl[PB][7];
    alt_in_next.analog_channel_inputs = mode_reg[PC];
    alt_in_next.byte_timer_b_count_input = mode_reg[PD][3] & lvl[PD][3];
    alt_in_next.key_irq_inputs        = mode_reg[PG] & lvl[PG];
    alt_in_next.i2c_clock_in          = mode_reg[PF][0] & lvl[PF][0];
    alt_in_next.i2c_data_in           = mode_reg[PF][1] & lvl[PF][1];
    alt_in_next.ext_lowvolt_detect_input = mode_reg[PL][0] & lvl[PL][0];
    alt_in_next.main_osc_connect      = mode_reg[PL][1] & mode_reg[PL][2];
    alt_in_next.sub_osc_connect       = mode_reg[PL][3] & mode_reg[PL][4];
    alt_in_next.main_ext_clock_input  = mode_reg[PL][2] & lvl[PL][2];
    alt_in_next.sub_ext_clock_input   = mode_reg[PL][4] & lvl[PL][4];
    alt_in_next.external_irq_inputs[NIRQ-1:0] = irq_lvl & irq_en;
    alt_in_next.external_irq_edges[NIRQ-1:0]  = irq_pulse;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      alt_in_reg <= '0;
    else if (ce)
      alt_in_reg <= alt_in_next;
  end
  assign alt_in = alt_in_reg;

  // =====================================================
  // register readback
  assign port_a_direction     = dir_reg[PA][6:0];
  assign port_b_direction     = dir_reg[PB];
  assign port_c_direction     = dir_reg[PC];
  assign port_d_direction     = dir_reg[PD][3:0];
  assign port_f_direction     = dir_reg[PF][1:0];
  assign port_g_direction     = dir_reg[PG];
  assign port_l_direction     = dir_reg[PL][4:0];
  assign port_a_pullup_select = pu_reg[PA][6:0];
  assign port_b_pullup_select = pu_reg[PB];
  assign port_d_pullup_select = pu_reg[PD][3:0];
  assign port_g_pullup_select = pu_reg[PG];
  assign port_l_pullup_select = pu_reg[PL][0:0];

  // =====================================================
  // checks
  logic any_oe, pu_clash;
  always_comb
  begin
    any_oe   = 1'b0;
    pu_clash = 1'b0;
    for (int p = 0; p < NP; p++)
    begin
      any_oe   = any_oe | (|pad[p].oe);
      pu_clash = pu_clash | (|(pad[p].pu & pad[p].oe));
    end
  end

  a_reset_inputs: assert property (@(posedge clk) disable iff (rst)
    $fell(rst) |-> !any_oe && mode_reg[PC] == `PMX_MODE_RST_C)
    else $error("pins not inputs or port c not analog after reset");
  a_pullup_gate: assert property (@(posedge clk) disable iff (rst)
    !pu_clash)
    else $error("pull-up left on a driven pin");
  a_dir_write: assert property (@(posedge clk) disable iff (rst)
    ce && cfg_wr && cfg_field == FLD_DIR && cfg_port == 3'h0
    |=> port_a_direction == $past(cfg_wdata[6:0]))
    else $error("port a direction write lost");
  a_l_pullup: assert property (@(posedge clk) disable iff (rst)
    ce && cfg_wr && cfg_field == FLD_PULLUP && cfg_port == 3'h6
    |=> pu_reg[PL] == ($past(cfg_wdata) & 8'h01))
    else $error("port l pull-up not limited to bit 0");
  a_alt_drive: assert property (@(posedge clk) disable iff (rst)
    mode_reg[PA][1] && alt_out.timer_a_out_en
    |-> pad[PA].oe[1] && pad[PA].out[1] == alt_out.timer_a_output)
    else $error("timer a output not on its pin");
  a_latch_hold: assert property (@(posedge clk) disable iff (rst)
    !(ce && cfg_wr && cfg_field == FLD_LATCH)
    |=> $stable(latch_reg[PA]))
    else $error("port a latch changed without a write");
  a_i2c_pull: assert property (@(posedge clk) disable iff (rst)
    mode_reg[PF][0] |-> pad[PF].oe[0] == alt_out.i2c_clock_low
      && !pad[PF].out[0])
    else $error("i2c clock pin not open-drain low");
  a_key_route: assert property (@(posedge clk) disable iff (rst)
    ce |=> alt_in.key_irq_inputs == $past(mode_reg[PG] & lvl[PG]))
    else $error("key irq inputs misrouted");
  a_i2c_data: assert property (@(posedge clk) disable iff (rst)
    ce |=> alt_in.i2c_data_in == $past(mode_reg[PF][1] & lvl[PF][1]))
    else $error("i2c data not taken from port f bit 1");
endmodule // pmx_top

// ### verif/pmx_board.sv
// board circuitry model: resolves pad drive, pull-ups and board levels
`timescale 1ns/1ps
module pmx_board (
  input  pmx_pkg::pmx_pad_t pad [7], // pad drive per port
  input  wire logic [7:0]   ext [7], // board-held levels
  output logic [7:0]        pin [7]  // resolved pin levels
);
  import pmx_pkg::*;
  // driver wins, else pull-up, else board level
  always_comb
    for (int p = 0; p < 7; p++)
      for (int b = 0; b < 8; b++)
        if (pad[p].oe[b])
          pin[p][b] = (p == 4) ? 1'b0 : pad[p].out[b];
        else
          pin[p][b] = pad[p].pu[b] | ext[p][b];
endmodule // pmx_board

// ### verif/port_pin_function_mux_tb_top.sv
// self-checking bench for the port pin function multiplexer
`timescale 1ns/1ps
module port_pin_function_mux_tb_top;
  import pmx_pkg::*;
  logic         clk = 0, rst = 1, cfg_wr = 0, ce = 1;
  logic [2:0]   cfg_port = 0;
  pmx_field_t   cfg_field = FLD_LATCH;
  logic [7:0]   cfg_wdata = 0;
  logic [7:0]   ext [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h00, 8'h00};
  logic [7:0]   pin [7], mode [7], lvl [7];
  pmx_pad_t     pad [7];
  pmx_alt_out_t alt_out = '0;
  pmx_alt_in_t  alt_in;
  logic [6:0]   dir_a;
  int           fail_count = 0, checks_done = 0, edges = 0;
  // ext[3][1] stays low through reset release
  always #12.5 clk = ~clk;
  pmx_top DUT (.clk(clk), .rst(rst), .ce(ce), .cfg_wr(cfg_wr),
    .cfg_port(cfg_port), .cfg_field(cfg_field), .cfg_wdata(cfg_wdata),
    .pad_in(pin), .pad(pad), .alt_out(alt_out), .alt_in(alt_in),
    .port_a_direction(dir_a), .port_b_direction(), .port_c_direction(),
    .port_d_direction(), .port_f_direction(), .port_g_direction(),
    .port_l_direction(), .port_a_pullup_select(),
    .port_b_pullup_select(), .port_d_pullup_select(),
    .port_g_pullup_select(), .port_l_pullup_select(),
    .port_mode(mode), .port_level(lvl));
  pmx_board board (.pad(pad), .ext(ext), .pin(pin));
  // count irq1 edge pulses
  always @(posedge clk)
    if (alt_in.external_irq_edges[1] === 1'b1)
      edges <= edges + 1;
  // ==========================================================
  // tasks
  task automatic wr(input logic [2:0] p, input pmx_field_t f,
                    input logic [7:0] d);
    @(negedge clk);
    cfg_wr = 1;
    cfg_port = p;
    cfg_field = f;
    cfg_wdata = d;
    @(negedge clk);
    cfg_wr = 0;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      $display("unexpected t=%0t got %h exp %h", $time, got, exp);
      fail_count++;
    end
  endtask
  task automatic final_report;
    if (fail_count == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // watchdog against a hang
  initial
  begin
    #100us;
    fail_count++;
    final_report;
  end
  // ==========================================================
  // test sequence
  initial
  begin
    repeat (10) @(negedge clk);
    rst = 0;
    chk(mode[2], 8'hFF);
    chk(mode[0] | mode[6], 8'h00);
    chk({1'b0, dir_a}, 8'h7F);
    chk(pad[0].oe | pad[3].oe | pad[6].oe, 8'h00);
    wr(0, FLD_LATCH, 8'hD5);
    wr(0, FLD_DIR, 8'h00);
    wr(0, FLD_PULLUP, 8'hFF);
    chk(pad[0].oe, 8'h7F);
    chk(pad[0].out, 8'h55);
    chk(pad[0].pu, 8'h00);
    wr(0, FLD_DIR, 8'hF0);
    chk(pad[0].pu, 8'h70);
    wr(6, FLD_PULLUP, 8'hFF);
    chk(pad[6].pu, 8'h01);
    wr(4, FLD_LATCH, 8'h02);
    wr(4, FLD_DIR, 8'h00);
    chk(pad[4].out, 8'h00);
    chk(pad[4].oe, 8'h01);
    wr(4, FLD_MODE, 8'h03);
    alt_out.i2c_data_low = 1;
    @(negedge clk);
    chk(pad[4].oe, 8'h02);
    wr(4, FLD_MODE, 8'h00);
    chk(pad[4].oe, 8'h01);
    // timer a output takes port a bit 1, latch kept underneath
    wr(0, FLD_MODE, 8'h02);
    alt_out.timer_a_output = 1;
    alt_out.timer_a_out_en = 1;
    @(negedge clk);
    chk(pad[0].out, 8'h57);
    chk(pad[0].oe, 8'h0F);
    wr(0, FLD_MODE, 8'h00);
    chk(pad[0].out, 8'h55);
    // clock enable low freezes the configuration
    ce = 0;
    wr(0, FLD_LATCH, 8'h00);
    ce = 1;
    chk(pad[0].out, 8'h55);
    // port g key inputs and port c analog channels
    wr(5, FLD_MODE, 8'hFF);
    ext[5] = 8'hA5;
    repeat (6) @(negedge clk);
    chk(lvl[5], 8'hA5);
    chk(alt_in.key_irq_inputs, 8'hA5);
    chk(alt_in.analog_channel_inputs, 8'hFF);
    // irq1 sits on port d bit 0: rise, fall, both
    wr(3, FLD_MODE, 8'h01);
    for (int s = 1; s < 4; s++)
    begin
      wr(1, FLD_EDGE, 8'(s));
      edges = 0;
      ext[3][0] = 1;
      repeat (8) @(negedge clk);
      ext[3][0] = 0;
      repeat (8) @(negedge clk);
      chk(8'(edges), (s == 3) ? 8'h02 : 8'h01);
    end
    final_report;
  end
endmodule // port_pin_function_mux_tb_top
